// ==== design/quad_t1_port_config.sv ====
`timescale 1ns/1ps
`default_nettype none

module quad_t1_port_config #(
    parameter longint DWELL_CYCLES = t1_cfg_pkg::DWELL_CYC
) (
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire logic [t1_cfg_pkg::AW-1:0]   addr,
    input  wire logic [t1_cfg_pkg::DW-1:0]   wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [t1_cfg_pkg::DW-1:0]   rdata,
    input  wire logic [3:0]                  port_installed,
    input  wire logic [9:0]                  blocks_used,
    input  wire t1_cfg_pkg::line_t [3:0]     line_in,
    input  wire logic [3:0]                  rx_clk,
    input  wire logic                        remote_clk,
    input  wire logic                        ds3_clk,
    output logic      [3:0]                  port_traffic_en,
    output logic      [7:0]                  frame_sel,
    output logic      [7:0]                  code_sel,
    output logic      [11:0]                 len_sel,
    output logic                             tx_timing_tick,
    output logic                             irq
);

    // *****************************************************
    // State
    // *****************************************************
    typedef struct packed {
        t1_cfg_pkg::pcfg_t [3:0] pend;
        t1_cfg_pkg::pcfg_t [3:0] act;
        t1_cfg_pkg::tsrc_t       tsrc_pend;
        t1_cfg_pkg::tsrc_t       tsrc_act;
        logic [3:0]              try_d4;
        logic [3:0]              locked;
        logic [3:0][31:0]        dwell;
        logic [3:0]              irq_st;
        logic [3:0]              irq_msk;
        logic [31:0]             rdata;
        logic [1:0][5:0]         sync;
        logic [5:0]              clk_last;
        logic                    tick;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // Sampled inputs: rx_clk[3:0], remote_clk, ds3_clk, with line status
    logic [5:0] raw_in;
    logic [5:0] clk_s;
    logic [3:0][1:0] ln_s1;
    logic [3:0][1:0] ln_s2;
    logic [5:0] rise;

    assign raw_in = {ds3_clk, remote_clk, rx_clk};
    assign clk_s  = st_reg.sync[1];
    assign rise   = clk_s & ~st_reg.clk_last;

    // Line status through two flops before use
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ln_s1 <= '0;
            ln_s2 <= '0;
        end
        else
        begin
            ln_s1 <= line_in;
            ln_s2 <= ln_s1;
        end
    end

    // Port status decode, used only by the status register read
    function automatic t1_cfg_pkg::pstat_t port_status(
        input logic inst, input logic en, input logic los,
        input logic lock);
        if (!inst)
            port_status = t1_cfg_pkg::ST_NOT_INST;
        else if (!en)
            port_status = t1_cfg_pkg::ST_INACTIVE;
        else if (los)
            port_status = t1_cfg_pkg::ST_ERROR;
        else if (!lock)
            port_status = t1_cfg_pkg::ST_WAITING;
        else
            port_status = t1_cfg_pkg::ST_ACTIVE;
    endfunction

    // *****************************************************
    // Next state
    // *****************************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.sync[0]  = raw_in;
        st_next.sync[1]  = st_reg.sync[0];
        st_next.clk_last = clk_s;

        // Transmit timing follows exactly one applied source
        case (st_reg.tsrc_act)
            t1_cfg_pkg::TS_DS3:    st_next.tick = rise[5];
            t1_cfg_pkg::TS_REMOTE: st_next.tick = rise[4];
            t1_cfg_pkg::TS_PORT1:  st_next.tick = rise[0];
            t1_cfg_pkg::TS_PORT2:  st_next.tick = rise[1];
            t1_cfg_pkg::TS_PORT3:  st_next.tick = rise[2];
            t1_cfg_pkg::TS_PORT4:  st_next.tick = rise[3];
            default:               st_next.tick = rise[5];
        endcase

        // Framing hunt per port; one timer each for independence
        for (int p = 0; p < 4; p++)
        begin
            if (!st_reg.act[p].en ||
                st_reg.act[p].frame != t1_cfg_pkg::FRM_AUTO)
            begin
                st_next.try_d4[p] = 1'b0;
                st_next.dwell[p]  = '0;
                st_next.locked[p] = st_reg.act[p].en & ln_s2[p][1];
            end
            else if (ln_s2[p][1])
            begin
                // Valid framing stops the hunt on the current try
                st_next.locked[p] = 1'b1;
                st_next.dwell[p]  = '0;
            end
            else if (st_reg.dwell[p] == 32'(DWELL_CYCLES - 1))
            begin
                st_next.dwell[p]  = '0;
                st_next.try_d4[p] = ~st_reg.try_d4[p];
                st_next.locked[p] = 1'b0;
            end
            else
            begin
                st_next.dwell[p]  = st_reg.dwell[p] + 32'h0000_0001;
                st_next.locked[p] = 1'b0;
            end
            // Loss of lock raises a sticky event
            if (st_reg.locked[p] && !st_next.locked[p])
                st_next.irq_st[p] = 1'b1;
        end

        // Register writes
        st_next.rdata = '0;
        if (wr)
        begin
            if (addr < t1_cfg_pkg::OFS_ACT0)
                st_next.pend[addr[1:0]] = wdata[7:0];
            else if (addr == t1_cfg_pkg::OFS_TIMING)
                st_next.tsrc_pend = t1_cfg_pkg::tsrc_t'(wdata[2:0]);
            else if (addr == t1_cfg_pkg::OFS_APPLY && wdata[0])
            begin
                st_next.act      = st_reg.pend;
                st_next.tsrc_act = st_reg.tsrc_pend;
            end
            else if (addr == t1_cfg_pkg::OFS_IRQ_MSK)
                st_next.irq_msk = wdata[3:0];
        end

        // Register reads, data one cycle later
        if (rd)
        begin
            case (addr)
                4'h0, 4'h1, 4'h2, 4'h3:
                    st_next.rdata = {24'h00_0000, st_reg.pend[addr[1:0]]};
                4'h4, 4'h5, 4'h6, 4'h7:
                    st_next.rdata = {24'h00_0000, st_reg.act[addr[1:0]]};
                t1_cfg_pkg::OFS_TIMING:
                    st_next.rdata = {29'h0, st_reg.tsrc_pend};
                t1_cfg_pkg::OFS_STATUS:
                begin
                    for (int p = 0; p < 4; p++)
                    begin
                        st_next.rdata[p*4 +: 3] = port_status(
                            port_installed[p], st_reg.act[p].en,
                            ln_s2[p][0], st_reg.locked[p]);
                        st_next.rdata[16+p*2 +: 2] =
                            (st_reg.act[p].frame == t1_cfg_pkg::FRM_AUTO)
                            ? {1'b0, st_reg.try_d4[p]}
                            : st_reg.act[p].frame;
                    end
                end
                t1_cfg_pkg::OFS_IRQ_ST:
                begin
                    st_next.rdata = {28'h000_0000, st_reg.irq_st};
                    // Clear on read, but a same-cycle event survives
                    for (int p = 0; p < 4; p++)
                        if (!(st_reg.locked[p] && !st_next.locked[p]))
                            st_next.irq_st[p] = 1'b0;
                end
                t1_cfg_pkg::OFS_IRQ_MSK:
                    st_next.rdata = {28'h000_0000, st_reg.irq_msk};
                t1_cfg_pkg::OFS_BLOCKS:
                    st_next.rdata = {22'h00_0000,
                        (blocks_used > t1_cfg_pkg::TOTAL_BLOCKS) ? 10'h000
                        : t1_cfg_pkg::TOTAL_BLOCKS - blocks_used};
                t1_cfg_pkg::OFS_IFTYPE:
                    st_next.rdata = {24'h00_0000, t1_cfg_pkg::IFTYPE_CODE};
                default:
                    st_next.rdata = '0;
            endcase
        end
    end

    // *****************************************************
    // Registers
    // *****************************************************
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            st_reg           <= '0;
            st_reg.pend      <= {4{t1_cfg_pkg::PCFG_RESET}};
            st_reg.act       <= {4{t1_cfg_pkg::PCFG_RESET}};
        end
        else
            st_reg <= st_next;
    end

    // *****************************************************
    // Outputs
    // *****************************************************
    // Same framing both ends is the operator's job; no conversion here
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            port_traffic_en[p] = st_reg.act[p].en
                                 & port_installed[p];
            frame_sel[p*2 +: 2] =
                (st_reg.act[p].frame == t1_cfg_pkg::FRM_AUTO)
                ? {1'b0, st_reg.try_d4[p]} : st_reg.act[p].frame;
            code_sel[p*2 +: 2] = st_reg.act[p].code;
            len_sel[p*3 +: 3]  = st_reg.act[p].len;
        end
    end

    assign rdata          = st_reg.rdata;
    assign tx_timing_tick = st_reg.tick;
    assign irq            = |(st_reg.irq_st & st_reg.irq_msk);

    // *****************************************************
    // Checks
    // *****************************************************
    a_apply_copies: assert property (@(posedge clk_sys) disable iff (reset)
        (wr && addr == t1_cfg_pkg::OFS_APPLY && wdata[0])
        |=> st_reg.act == $past(st_reg.pend))
        else $error("apply did not copy pending settings");

    a_apply_timing: assert property (@(posedge clk_sys) disable iff (reset)
        (wr && addr == t1_cfg_pkg::OFS_APPLY && wdata[0])
        |=> st_reg.tsrc_act == $past(st_reg.tsrc_pend))
        else $error("apply did not copy timing source");

    a_no_apply_hold: assert property (@(posedge clk_sys) disable iff (reset)
        !(wr && addr == t1_cfg_pkg::OFS_APPLY) |=> $stable(st_reg.act))
        else $error("active settings changed without apply");

    a_disabled_idle: assert property (@(posedge clk_sys) disable iff (reset)
        !st_reg.act[0].en |-> !port_traffic_en[0])
        else $error("disabled port carries traffic");

    sequence s_hunting0;
        st_reg.act[0].en && st_reg.act[0].frame == t1_cfg_pkg::FRM_AUTO
        && !ln_s2[0][1];
    endsequence

    a_dwell_hold: assert property (@(posedge clk_sys) disable iff (reset)
        s_hunting0 ##1 (s_hunting0 and (st_reg.dwell[0] != '0))
        |-> $stable(st_reg.try_d4[0]))
        else $error("candidate changed inside dwell");

    a_dwell_toggle: assert property (@(posedge clk_sys) disable iff (reset)
        s_hunting0 and st_reg.dwell[0] == 32'(DWELL_CYCLES - 1)
        |=> st_reg.try_d4[0] != $past(st_reg.try_d4[0]))
        else $error("auto framing did not toggle");

    a_read_latency: assert property (@(posedge clk_sys) disable iff (reset)
        (rd && addr == t1_cfg_pkg::OFS_IFTYPE)
        |=> rdata == {24'h00_0000, t1_cfg_pkg::IFTYPE_CODE})
        else $error("interface type read wrong");

    a_ds3_tick: assert property (@(posedge clk_sys) disable iff (reset)
        st_reg.tsrc_act == t1_cfg_pkg::TS_DS3 && rise[5] |=> tx_timing_tick)
        else $error("DS3 timing edge missed");

    a_status_absent: assert property (@(posedge clk_sys) disable iff (reset)
        (rd && addr == t1_cfg_pkg::OFS_STATUS && !port_installed[0])
        |=> rdata[2:0] == t1_cfg_pkg::ST_NOT_INST)
        else $error("absent port not reported");

endmodule

`default_nettype wire

// ==== pkg/t1_cfg_pkg.sv ====
package t1_cfg_pkg;

    // *****************************************************
    // Sizes and register map
    // *****************************************************
    localparam int NUM_PORTS = 4;
    localparam int AW        = 4;
    localparam int DW        = 32;

    localparam logic [3:0] OFS_PEND0   = 4'h0; // Pending port 0..3 at 0..3
    localparam logic [3:0] OFS_ACT0    = 4'h4; // Active port 0..3 at 4..7
    localparam logic [3:0] OFS_TIMING  = 4'h8;
    localparam logic [3:0] OFS_APPLY   = 4'h9;
    localparam logic [3:0] OFS_STATUS  = 4'hA;
    localparam logic [3:0] OFS_IRQ_ST  = 4'hB;
    localparam logic [3:0] OFS_IRQ_MSK = 4'hC;
    localparam logic [3:0] OFS_BLOCKS  = 4'hD;
    localparam logic [3:0] OFS_IFTYPE  = 4'hE;

    // Field positions in a port config word
    localparam int FLD_EN    = 0;
    localparam int FLD_FRAME = 1; // 2 bits
    localparam int FLD_CODE  = 3; // 2 bits
    localparam int FLD_LEN   = 5; // 3 bits

    // *****************************************************
    // Encodings
    // *****************************************************
    typedef enum logic [1:0] {
        FRM_ESF  = 2'b00,
        FRM_D4   = 2'b01,
        FRM_AUTO = 2'b10
    } frame_t;

    typedef enum logic [1:0] {
        CODE_B8ZS    = 2'b00,
        CODE_AMI     = 2'b01,
        CODE_AMI_STF = 2'b10
    } code_t;

    // Line length: 0..4 distance bands, 5 = 7.5 dB pad
    localparam logic [2:0] LEN_DEFAULT = 3'h4;
    localparam logic [2:0] LEN_PAD_7DB5 = 3'h5;

    typedef enum logic [2:0] {
        ST_INACTIVE  = 3'b000,
        ST_ACTIVE    = 3'b001,
        ST_WAITING   = 3'b010,
        ST_ERROR     = 3'b011,
        ST_NOT_INST  = 3'b100
    } pstat_t;

    typedef enum logic [2:0] {
        TS_DS3    = 3'b000,
        TS_REMOTE = 3'b001,
        TS_PORT1  = 3'b100,
        TS_PORT2  = 3'b101,
        TS_PORT3  = 3'b110,
        TS_PORT4  = 3'b111
    } tsrc_t;

    typedef struct packed {
        logic [2:0] len;
        code_t      code;
        frame_t     frame;
        logic       en;
    } pcfg_t;

    localparam pcfg_t PCFG_RESET = '{len: 3'h4, code: CODE_B8ZS,
                                     frame: FRM_ESF, en: 1'b0};

    // Arbitrary neutral card type code
    localparam logic [7:0] IFTYPE_CODE = 8'h01;
    localparam logic [9:0] TOTAL_BLOCKS = 10'h24C; // 588

    // *****************************************************
    // Timing
    // *****************************************************
    localparam longint CLK_HZ      = 20000000;
    localparam longint DWELL_S     = 10;
    localparam longint DWELL_CYC   = DWELL_S * CLK_HZ;

    // Per-port line side inputs (after link-clock sampling)
    typedef struct packed {
        logic frame_ok;
        logic los;
    } line_t;

endpackage

// ==== dv/t1_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// *****************************************************
// Line side and far-end card model
// *****************************************************
module t1_line_model (
    input  wire logic [3:0]             lock_ok,
    input  wire logic [7:0]             dte_fmt,
    input  wire logic [3:0]             los_on,
    input  wire logic [5:0]             clk_on,
    input  wire logic [7:0]             frame_sel,
    output var  t1_cfg_pkg::line_t [3:0] line_in,
    output logic      [3:0]             rx_clk,
    output logic                        remote_clk,
    output logic                        ds3_clk
);
    logic ph = 1'b0;

    // One 400 ns reference; a stopped source stands low, not mid-swing
    always #200 ph = ~ph;

    // Only the sources the bench enables run, so one reference exists
    assign ds3_clk    = ph & clk_on[0];
    assign remote_clk = ph & clk_on[1];
    assign rx_clk     = {4{ph}} & clk_on[5:2];

    // Lock only on a matching format; no ESF to D4 conversion
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            line_in[p].frame_ok = lock_ok[p]
                & (frame_sel[2*p+:2] == dte_fmt[2*p+:2]);
            line_in[p].los      = los_on[p];
        end
    end
endmodule

`default_nettype wire

// ==== dv/quad_t1_port_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module quad_t1_port_config_tb;
    logic                    clk_sys = 1'b0;
    logic                    reset;
    logic [3:0]              addr;
    logic [31:0]             wdata;
    logic                    wr;
    logic                    rd;
    logic [31:0]             rdata;
    logic [3:0]              port_installed;
    logic [9:0]              blocks_used;
    t1_cfg_pkg::line_t [3:0] line_in;
    logic [3:0]              rx_clk;
    logic                    remote_clk;
    logic                    ds3_clk;
    logic [3:0]              port_traffic_en;
    logic [7:0]              frame_sel;
    logic [7:0]              code_sel;
    logic [11:0]             len_sel;
    logic                    tx_timing_tick;
    logic                    irq;
    logic [3:0]              lock_ok;
    logic [7:0]              dte_fmt;
    logic [3:0]              los_on;
    logic [5:0]              clk_on;
    int                      errors = 0;
    int                      compares = 0;
    t1_cfg_pkg::pcfg_t       cur [4];
    logic [31:0]             d;
    logic [31:0]             q;
    int                      n;
    logic [1:0]              last;
    logic [2:0]              srcs [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};

    // *****************************************************
    // Clock, design and far side
    // *****************************************************
    always #25 clk_sys = ~clk_sys;

    quad_t1_port_config #(.DWELL_CYCLES(20)) quad_t1_port_config_inst (
        .clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .port_installed(port_installed),
        .blocks_used(blocks_used), .line_in(line_in), .rx_clk(rx_clk),
        .remote_clk(remote_clk), .ds3_clk(ds3_clk),
        .port_traffic_en(port_traffic_en), .frame_sel(frame_sel),
        .code_sel(code_sel), .len_sel(len_sel),
        .tx_timing_tick(tx_timing_tick), .irq(irq));

    t1_line_model t1_line_model_inst (
        .lock_ok(lock_ok), .dte_fmt(dte_fmt), .los_on(los_on),
        .clk_on(clk_on), .frame_sel(frame_sel), .line_in(line_in),
        .rx_clk(rx_clk), .remote_clk(remote_clk), .ds3_clk(ds3_clk));

    // *****************************************************
    // Bus cycles and comparison
    // *****************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    // Check driven selects and traffic enables against the applied set
    task automatic chk_out();
        for (int p = 0; p < 4; p++)
        begin
            chk(frame_sel[2*p+:2], cur[p].frame);
            chk(code_sel[2*p+:2], cur[p].code);
            chk(len_sel[3*p+:3], cur[p].len);
            chk(port_traffic_en[p], cur[p].en & port_installed[p]);
        end
    endtask

    // Count timing ticks over a fixed span
    task automatic ticks(input int cyc, output int cnt);
        cnt = 0;
        repeat (cyc)
        begin
            @(posedge clk_sys);
            #1 cnt += tx_timing_tick;
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the few thousand cycles the tests need
    initial
    begin
        #(40000 * 50);
        errors++;
        summarize();
    end

    // *****************************************************
    // Tests
    // *****************************************************
    initial
    begin
        {reset, wr, rd, addr, wdata, blocks_used} = '0;
        reset = 1'b1;
        {lock_ok, dte_fmt, los_on, clk_on} = '0;
        port_installed = 4'hF;
        void'($urandom(5911));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        for (int p = 0; p < 4; p++)
        begin
            cur[p] = t1_cfg_pkg::PCFG_RESET;
            rd_reg(p[3:0], d);
            chk(d, {24'h0, t1_cfg_pkg::PCFG_RESET});
        end
        chk_out();
        rd_reg(t1_cfg_pkg::OFS_IFTYPE, d);
        chk(d, {24'h0, t1_cfg_pkg::IFTYPE_CODE});
        rd_reg(4'hF, d);
        chk(d, 32'h0000_0000);
        $display("test reset done");

        // Unallocated blocks, with both ends of the range
        for (int i = 0; i < 6; i++)
        begin
            n = (i == 0) ? 588 : (i == 1) ? 0 : $urandom_range(588, 0);
            blocks_used <= n[9:0];
            rd_reg(t1_cfg_pkg::OFS_BLOCKS, d);
            chk(d, 32'(588 - n));
        end
        $display("test blocks done");

        // Pending sets must not move the port 0 active copy until apply
        for (int t = 0; t < 8; t++)
        begin
            for (int p = 0; p < 4; p++)
            begin
                wr_reg(p[3:0], 32'(8'($urandom())) & 32'h0000_00FB);
            end
            for (int p = 0; p < 4; p++)
            begin
                cur[p].en    = 1'($urandom());
                cur[p].frame = t1_cfg_pkg::frame_t'($urandom_range(1, 0));
                cur[p].code  = t1_cfg_pkg::code_t'($urandom_range(2, 0));
                cur[p].len   = 3'($urandom_range(5, 0));
            end
            cur[t % 4].len = t1_cfg_pkg::LEN_PAD_7DB5;
            rd_reg(4'h4, d);
            for (int p = 0; p < 4; p++)
            begin
                wr_reg(p[3:0], {24'h0, cur[p]});
            end
            port_installed <= 4'($urandom());
            rd_reg(4'h4, q);
            chk(q, d);
            wr_reg(t1_cfg_pkg::OFS_APPLY, 32'h0000_0001);
            @(posedge clk_sys);
            #1;
            chk_out();
            for (int p = 0; p < 4; p++)
            begin
                rd_reg(4'(4 + p), d);
                chk(d, {24'h0, cur[p]});
            end
        end
        $display("test apply done");

        // One port per status kind; port 3 later removed
        port_installed <= 4'hF;
        lock_ok <= 4'b0010;
        los_on  <= 4'b1000;
        for (int p = 0; p < 4; p++)
        begin
            wr_reg(p[3:0], (p == 0) ? 32'h0000_0000 : 32'h0000_0001);
        end
        wr_reg(t1_cfg_pkg::OFS_APPLY, 32'h0000_0001);
        repeat (10) @(posedge clk_sys);
        rd_reg(t1_cfg_pkg::OFS_STATUS, d);
        chk(d, 32'h0000_3210);
        port_installed <= 4'b0111;
        repeat (4) @(posedge clk_sys);
        rd_reg(t1_cfg_pkg::OFS_STATUS, d);
        chk(d, 32'h0000_4210);
        $display("test status done");

        // Auto hunt on port 0 against a D4 line that is not yet up
        dte_fmt <= 8'h01;
        wr_reg(4'h0, 32'h0000_0005);
        wr_reg(t1_cfg_pkg::OFS_APPLY, 32'h0000_0001);
        n = 0;
        last = frame_sel[1:0];
        repeat (70)
        begin
            @(posedge clk_sys);
            #1 n += (frame_sel[1:0] != last);
            last = frame_sel[1:0];
        end
        chk(32'(n >= 2 && n <= 4), 32'h1);
        lock_ok[0] <= 1'b1;
        repeat (60) @(posedge clk_sys);
        chk(frame_sel[1:0], t1_cfg_pkg::FRM_D4);
        n = 0;
        repeat (60)
        begin
            @(posedge clk_sys);
            #1 n += (frame_sel[1:0] != 2'b01);
        end
        chk(n, 0);
        rd_reg(t1_cfg_pkg::OFS_STATUS, d);
        chk(d, 32'h0001_4211);
        $display("test auto done");

        // Loss of lock: sticky, masked, then cleared by read
        rd_reg(t1_cfg_pkg::OFS_IRQ_ST, d);
        wr_reg(t1_cfg_pkg::OFS_IRQ_MSK, 32'h0000_0000);
        lock_ok[0] <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(irq, 1'b0);
        wr_reg(t1_cfg_pkg::OFS_IRQ_MSK, 32'h0000_0001);
        @(posedge clk_sys);
        chk(irq, 1'b1);
        rd_reg(t1_cfg_pkg::OFS_IRQ_ST, d);
        chk(d, 32'h0000_0001);
        @(posedge clk_sys);
        chk(irq, 1'b0);
        $display("test irq done");

        // Each timing source alone drives the ticks
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(t1_cfg_pkg::OFS_TIMING, {29'h0, srcs[i]});
            wr_reg(t1_cfg_pkg::OFS_APPLY, 32'h0000_0001);
            clk_on <= 6'(1 << i);
            repeat (10) @(posedge clk_sys);
            ticks(160, n);
            chk(32'(n >= 18 && n <= 22), 32'h1);
            clk_on <= ~6'(1 << i);
            repeat (10) @(posedge clk_sys);
            ticks(80, n);
            chk(n, 0);
        end
        $display("test timing done");
        summarize();
    end
endmodule

`default_nettype wire
